// [src/fpca_map.vh]
// Register map, field positions, reset values and timing of the pulse counter
`ifndef FPCA_MAP_VH
`define FPCA_MAP_VH

// Shared operating modes
`define FPCA_MODE_UPDN 2'h0
`define FPCA_MODE_BIDIR 2'h1
`define FPCA_MODE_FREQ 2'h2

// Global register word addresses
`define FPCA_A_CTRL 8'h00
`define FPCA_A_ALCFG 8'h01
`define FPCA_A_CLRL 8'h02
`define FPCA_A_ALST 8'h03
`define FPCA_A_RTHI 8'h04
`define FPCA_A_RTLO 8'h05
`define FPCA_A_ISTAT 8'h06
`define FPCA_A_ICLR 8'h07
`define FPCA_A_IEN 8'h08

// Per-channel block: base plus channel times stride
`define FPCA_A_CH_BASE 8'h10
`define FPCA_CH_SPAN 8'h20
`define FPCA_S_INIT 3'h0
`define FPCA_S_HILIM 3'h1
`define FPCA_S_LOLIM 3'h2
`define FPCA_S_COUNT 3'h3
`define FPCA_S_OVF 3'h4
`define FPCA_S_FREQ 3'h5

// Control fields
`define FPCA_F_MODE 1:0
`define FPCA_F_TTL 2
`define FPCA_CTRL_W 3

// Alarm vectors: high alarms low nibble, low alarms high nibble
`define FPCA_ALM_W 8

// Route byte: enable, slot, output channel
`define FPCA_RT_EN 7
`define FPCA_RT_IDX 6:0
`define FPCA_RT_W 8
`define FPCA_DO_W 128

// Interrupt event layout
`define FPCA_EV_ALM 7:0
`define FPCA_EV_OVF 11:8
`define FPCA_EV_FRQ 12
`define FPCA_EV_W 13

// Reset values and fixed counter range
`define FPCA_RST_INIT 32'h00000000
`define FPCA_RST_HILIM 32'hFFFFFFFF
`define FPCA_RST_LOLIM 32'h00000000
`define FPCA_CNT_MAX 32'hFFFFFFFF
`define FPCA_CNT_MIN 32'h00000000
`define FPCA_ONE 32'h00000001

// Frequency gate timing
`define FPCA_CLK_KHZ 200000
`define FPCA_GATE_MS 1000
`define FPCA_GATE_CYC (`FPCA_GATE_MS * `FPCA_CLK_KHZ)
`define FPCA_SCALE (1000 / `FPCA_GATE_MS)

`endif

// [src/fpca_sync.v]
// Two-flop synchroniser for a vector of field pins
`timescale 1ns/10ps
`default_nettype none
module fpca_sync #(
  parameter W = 16
) (
  // Clock and reset
  input wire clk,
  input wire sys_rst,
  input wire ce,
  // Pins in, synchronised levels out
  input wire [W-1:0] d_in,
  output reg [W-1:0] q_out
);

  reg [W-1:0] meta_q;

  // First stage feeds only the second
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_q <= {W{1'b0}};
      q_out <= {W{1'b0}};
    end else if (ce) begin
      meta_q <= d_in;
      q_out <= meta_q;
    end
  end

endmodule // fpca_sync
`default_nettype wire

// [src/fpca_top.v]
// Four-channel pulse counter and frequency unit with limit alarms
//
// The implementer's own choices: the register addresses and the address-and-strobe port.
`include "fpca_map.vh"
`timescale 1ns/10ps
`default_nettype none
module fpca_top #(
  parameter NCH = 4,
  parameter [31:0] GATE_CYCLES = `FPCA_GATE_CYC,
  parameter [31:0] FREQ_SCALE = `FPCA_SCALE
) (
  // Clock, reset, enable
  input wire clk,
  input wire sys_rst,
  input wire ce,
  // Register port
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  // Field inputs, one bit per channel
  input wire [NCH-1:0] up_count_input_pos,
  input wire [NCH-1:0] up_count_input_neg,
  input wire [NCH-1:0] down_input_pos,
  input wire [NCH-1:0] down_input_neg,
  // Alarm outputs
  output reg [`FPCA_ALM_W-1:0] alarm_state,
  output reg [`FPCA_DO_W-1:0] alarm_do,
  // Interrupt
  output reg irq
);

  reg [`FPCA_CTRL_W-1:0] ctrl_q;
  reg [`FPCA_ALM_W-1:0] alcfg_q, clr_pend_q, alm_q, alm_d, clr_pend_d;
  reg [31:0] rt_hi_q, rt_lo_q, gate_q, rd_d;
  reg [`FPCA_EV_W-1:0] ist_q, ien_q, ist_d;
  reg [NCH-1:0] up_prev_q, dn_prev_q;
  reg [`FPCA_DO_W-1:0] do_d;
  integer k;

  wire [1:0] mode_q = ctrl_q[`FPCA_F_MODE];
  wire ttl_q = ctrl_q[`FPCA_F_TTL];
  wire cnt_mode = (mode_q == `FPCA_MODE_UPDN) ||
                  (mode_q == `FPCA_MODE_BIDIR);
  wire frq_mode = (mode_q == `FPCA_MODE_FREQ);

  // Pin synchronisation, all 16 pins in one bank
  wire [4*NCH-1:0] pins_s;
  fpca_sync #(
    .W(4 * NCH)
  ) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .d_in({down_input_neg, down_input_pos,
           up_count_input_neg, up_count_input_pos}),
    .q_out(pins_s)
  );
  wire [NCH-1:0] up_pos_s = pins_s[NCH-1:0];
  wire [NCH-1:0] up_neg_s = pins_s[2*NCH-1:NCH];
  wire [NCH-1:0] dn_pos_s = pins_s[3*NCH-1:2*NCH];
  wire [NCH-1:0] dn_neg_s = pins_s[4*NCH-1:3*NCH];

  // TTL pin idles high through its pull-up; isolated pair idles off
  wire [NCH-1:0] up_lvl = ttl_q ? up_pos_s : (up_pos_s & ~up_neg_s);
  wire [NCH-1:0] dn_lvl = ttl_q ? dn_pos_s : (dn_pos_s & ~dn_neg_s);
  wire [NCH-1:0] up_rise = up_lvl & ~up_prev_q;
  wire [NCH-1:0] dn_rise = dn_lvl & ~dn_prev_q;

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      up_prev_q <= {NCH{1'b0}};
      dn_prev_q <= {NCH{1'b0}};
    end else if (ce) begin
      up_prev_q <= up_lvl;
      dn_prev_q <= dn_lvl;
    end
  end

  // Register decode
  wire wr = reg_wr & ce;
  wire [7:0] ch_off = reg_addr - `FPCA_A_CH_BASE;
  wire ch_hit = (reg_addr >= `FPCA_A_CH_BASE) && (ch_off < `FPCA_CH_SPAN);
  wire [1:0] ch_idx = ch_off[4:3];
  wire [2:0] ch_sub = ch_off[2:0];
  wire wr_ch = wr && ch_hit;

  // Frequency gate; free-running only in frequency mode
  wire gate_end = frq_mode && (gate_q == GATE_CYCLES - `FPCA_ONE);
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      gate_q <= 32'h00000000;
    end else if (ce) begin
      if (!frq_mode || gate_end) begin
        gate_q <= 32'h00000000;
      end else begin
        gate_q <= gate_q + `FPCA_ONE;
      end
    end
  end

  // Per-channel counters
  wire [32*NCH-1:0] init_f, hil_f, lol_f, cnt_f, ovf_f, frq_f;
  wire [NCH-1:0] hi_cond, lo_cond, ovf_ev;

  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi = gi + 1) begin : g_ch
      localparam [31:0] MY_ID = gi;
      reg [31:0] init_q, hil_q, lol_q, cnt_q, ovf_q, frq_q, pcnt_q;
      reg inc, dec;
      wire up_e = up_rise[gi];
      wire dn_e = dn_rise[gi];
      wire dir = dn_lvl[gi];
      wire wr_me = wr_ch && ({30'h0, ch_idx} == MY_ID);
      wire ld_init = wr_me && (ch_sub == `FPCA_S_INIT);
      wire at_max = (cnt_q == `FPCA_CNT_MAX);
      wire at_min = (cnt_q == `FPCA_CNT_MIN);
      // Full-width product; only the low word is reported
      wire [63:0] prod = {32'h00000000, pcnt_q} * {32'h00000000, FREQ_SCALE};

      // One mode register drives every channel
      always @* begin
        inc = 1'b0;
        dec = 1'b0;
        case (mode_q)
          `FPCA_MODE_UPDN: begin
            inc = up_e & ~dn_e;
            dec = dn_e & ~up_e;
          end
          `FPCA_MODE_BIDIR: begin
            inc = up_e & dir;
            dec = up_e & ~dir;
          end
          default: begin
            inc = 1'b0;
            dec = 1'b0;
          end
        endcase
      end

      always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          init_q <= `FPCA_RST_INIT;
          hil_q <= `FPCA_RST_HILIM;
          lol_q <= `FPCA_RST_LOLIM;
          cnt_q <= `FPCA_RST_INIT;
          ovf_q <= 32'h00000000;
          frq_q <= 32'h00000000;
          pcnt_q <= 32'h00000000;
        end else if (ce) begin
          // Loading the initial value restarts the totalizer
          if (ld_init) begin
            init_q <= reg_wdata;
            cnt_q <= reg_wdata;
            ovf_q <= 32'h00000000;
          end else if (inc) begin
            if (at_max) begin
              cnt_q <= init_q;
              ovf_q <= ovf_q + `FPCA_ONE;
            end else begin
              cnt_q <= cnt_q + `FPCA_ONE;
            end
          end else if (dec) begin
            if (at_min) begin
              cnt_q <= init_q;
              ovf_q <= ovf_q - `FPCA_ONE;
            end else begin
              cnt_q <= cnt_q - `FPCA_ONE;
            end
          end
          if (wr_me && (ch_sub == `FPCA_S_HILIM)) begin
            hil_q <= reg_wdata;
          end
          if (wr_me && (ch_sub == `FPCA_S_LOLIM)) begin
            lol_q <= reg_wdata;
          end
          // Only the up pair feeds the frequency gate
          if (!frq_mode) begin
            pcnt_q <= 32'h00000000;
          end else if (gate_end) begin
            frq_q <= prod[31:0];
            pcnt_q <= {31'h00000000, up_e};
          end else if (up_e) begin
            pcnt_q <= pcnt_q + `FPCA_ONE;
          end
        end
      end

      assign init_f[32*gi +: 32] = init_q;
      assign hil_f[32*gi +: 32] = hil_q;
      assign lol_f[32*gi +: 32] = lol_q;
      assign cnt_f[32*gi +: 32] = cnt_q;
      assign ovf_f[32*gi +: 32] = ovf_q;
      assign frq_f[32*gi +: 32] = frq_q;
      assign hi_cond[gi] = cnt_q > hil_q;
      assign lo_cond[gi] = cnt_q < lol_q;
      assign ovf_ev[gi] = ce && !ld_init && ((inc && at_max) ||
                                             (dec && at_min));
    end
  endgenerate

  // Alarm latches; a new trigger beats a pending clear
  wire [`FPCA_ALM_W-1:0] alm_set = {lo_cond, hi_cond} & alcfg_q &
                                   {`FPCA_ALM_W{cnt_mode}};
  wire [`FPCA_ALM_W-1:0] alm_trig = alm_set & ~alm_q;
  wire wr_clrl = wr && (reg_addr == `FPCA_A_CLRL);

  always @* begin
    alm_d = (alm_q & ~clr_pend_q) | alm_set;
    clr_pend_d = clr_pend_q & alm_q;
    if (wr_clrl) begin
      clr_pend_d = clr_pend_d | reg_wdata[`FPCA_ALM_W-1:0];
    end
  end

  // Interrupt status: set wins over clear
  wire [`FPCA_EV_W-1:0] ev = {gate_end & ce, ovf_ev, alm_trig & {8{ce}}};
  always @* begin
    ist_d = ist_q | ev;
    if (wr && (reg_addr == `FPCA_A_ICLR)) begin
      ist_d = (ist_q & ~reg_wdata[`FPCA_EV_W-1:0]) | ev;
    end
  end

  // Alarm routing to digital outputs, slot and channel per alarm
  wire [2*32-1:0] rt_all = {rt_lo_q, rt_hi_q};
  always @* begin
    do_d = {`FPCA_DO_W{1'b0}};
    for (k = 0; k < `FPCA_ALM_W; k = k + 1) begin
      if (rt_all[k*`FPCA_RT_W + `FPCA_RT_EN]) begin
        do_d[rt_all[k*`FPCA_RT_W +: 7]] =
          do_d[rt_all[k*`FPCA_RT_W +: 7]] | alm_q[k];
      end
    end
  end

  // Control registers
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_q <= {`FPCA_CTRL_W{1'b0}};
      alcfg_q <= {`FPCA_ALM_W{1'b0}};
      clr_pend_q <= {`FPCA_ALM_W{1'b0}};
      alm_q <= {`FPCA_ALM_W{1'b0}};
      rt_hi_q <= 32'h00000000;
      rt_lo_q <= 32'h00000000;
      ist_q <= {`FPCA_EV_W{1'b0}};
      ien_q <= {`FPCA_EV_W{1'b0}};
    end else if (ce) begin
      clr_pend_q <= clr_pend_d;
      alm_q <= alm_d;
      ist_q <= ist_d;
      if (wr && (reg_addr == `FPCA_A_CTRL)) begin
        ctrl_q <= reg_wdata[`FPCA_CTRL_W-1:0];
      end
      if (wr && (reg_addr == `FPCA_A_ALCFG)) begin
        alcfg_q <= reg_wdata[`FPCA_ALM_W-1:0];
      end
      if (wr && (reg_addr == `FPCA_A_RTHI)) begin
        rt_hi_q <= reg_wdata;
      end
      if (wr && (reg_addr == `FPCA_A_RTLO)) begin
        rt_lo_q <= reg_wdata;
      end
      if (wr && (reg_addr == `FPCA_A_IEN)) begin
        ien_q <= reg_wdata[`FPCA_EV_W-1:0];
      end
    end
  end

  // Read mux; unmapped and write-only words read zero
  always @* begin
    rd_d = 32'h00000000;
    if (ch_hit) begin
      case (ch_sub)
        `FPCA_S_INIT: rd_d = init_f[32*ch_idx +: 32];
        `FPCA_S_HILIM: rd_d = hil_f[32*ch_idx +: 32];
        `FPCA_S_LOLIM: rd_d = lol_f[32*ch_idx +: 32];
        `FPCA_S_COUNT: rd_d = cnt_f[32*ch_idx +: 32];
        `FPCA_S_OVF: rd_d = ovf_f[32*ch_idx +: 32];
        `FPCA_S_FREQ: rd_d = frq_f[32*ch_idx +: 32];
        default: rd_d = 32'h00000000;
      endcase
    end else begin
      case (reg_addr)
        `FPCA_A_CTRL: rd_d = {29'h00000000, ctrl_q};
        `FPCA_A_ALCFG: rd_d = {24'h000000, alcfg_q};
        `FPCA_A_CLRL: rd_d = {24'h000000, clr_pend_q};
        `FPCA_A_ALST: rd_d = {24'h000000, alm_q};
        `FPCA_A_RTHI: rd_d = rt_hi_q;
        `FPCA_A_RTLO: rd_d = rt_lo_q;
        `FPCA_A_ISTAT: rd_d = {19'h00000, ist_q};
        `FPCA_A_IEN: rd_d = {19'h00000, ien_q};
        default: rd_d = 32'h00000000;
      endcase
    end
  end

  // Registered outputs; read data valid only the cycle after the strobe
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 32'h00000000;
      alarm_state <= {`FPCA_ALM_W{1'b0}};
      alarm_do <= {`FPCA_DO_W{1'b0}};
      irq <= 1'b0;
    end else if (ce) begin
      reg_rdata <= reg_rd ? rd_d : 32'h00000000;
      alarm_state <= alm_q;
      alarm_do <= do_d;
      irq <= |(ist_q & ien_q);
    end
  end

endmodule // fpca_top
`default_nettype wire

// [verif/fpca_checker_assertions.sv]
// Port-level checker for the pulse counter top
`timescale 1ns/10ps
`default_nettype none
module fpca_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // Alarm and interrupt outputs
  input wire logic [7:0] alarm_state,
  input wire logic [127:0] alarm_do,
  input wire logic irq
);
  logic clr_seen_q;
  logic ien_zero_q;
  logic ien0_q;
  logic [1:0] mode_q;
  // Shadows of host writes, so outputs can be tied to their causes
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      clr_seen_q <= 1'b0;
      ien_zero_q <= 1'b1;
      ien0_q <= 1'b0;
      mode_q <= 2'h0;
    end else if (reg_wr) begin
      if (reg_addr == 8'h02 && reg_wdata[7:0] != 8'h00) begin
        clr_seen_q <= 1'b1;
      end
      if (reg_addr == 8'h08) begin
        ien_zero_q <= (reg_wdata[12:0] == 13'h0);
        ien0_q <= reg_wdata[0];
      end
      if (reg_addr == 8'h00) begin
        mode_q <= reg_wdata[1:0];
      end
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data not zero outside its slot");
  a_unmapped_zero: assert property (reg_rd && (reg_addr == 8'h09
    || reg_addr == 8'h07 || (reg_addr[7:4] == 4'h1 && reg_addr[2:1] == 2'h3))
    |=> reg_rdata == 32'h0) else $error("unmapped read not zero");
  a_mode_readback: assert property (reg_wr && reg_addr == 8'h00
    ##1 !reg_wr ##1 reg_rd && reg_addr == 8'h00
    |=> reg_rdata == {29'h0, $past(reg_wdata[2:0], 3)})
    else $error("control readback wrong");
  a_do_needs_alarm: assert property (alarm_do != 128'h0 |->
    alarm_state != 8'h00) else $error("output set without alarm");
  a_latch_holds: assert property (
    (($past(alarm_state) & ~alarm_state) != 8'h00) |-> clr_seen_q)
    else $error("alarm dropped without clear");
  a_irq_masked: assert property (ien_zero_q && $past(ien_zero_q) |-> !irq)
    else $error("interrupt while all masked");
  a_irq_on_alarm: assert property ($rose(alarm_state[0]) && ien0_q
    |-> ##[0:2] irq) else $error("no interrupt after alarm");
  a_freq_no_alarm: assert property (mode_q == 2'h2
    && $past(mode_q) == 2'h2 && $past(mode_q, 2) == 2'h2
    |-> ($past(alarm_state) & ~alarm_state) == ($past(alarm_state)
    ^ alarm_state)) else $error("alarm set in frequency mode");
  c_alarm: cover property ($rose(alarm_state[0]));
  c_route: cover property (alarm_do != 128'h0);
  c_irq: cover property ($rose(irq));
endmodule // fpca_checker
bind fpca_top fpca_checker i_chk (.clk(clk), .sys_rst(sys_rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .alarm_state(alarm_state),
  .alarm_do(alarm_do), .irq(irq));
`default_nettype wire

// [verif/fpca_field_src.sv]
// Field pulse source model driving the counter's input pairs
`timescale 1ns/10ps
`default_nettype none
module fpca_field_src (
  // Clock
  input wire logic clk,
  // Up pair and down or direction pair, bit per channel
  output logic [3:0] up_pos,
  output logic [3:0] up_neg,
  output logic [3:0] dn_pos,
  output logic [3:0] dn_neg
);
  initial begin
    up_pos = 4'h0;
    up_neg = 4'h0;
    dn_pos = 4'h0;
    dn_neg = 4'h0;
  end
  // Unconnected direction: TTL pull-up reads 1, isolated pair reads 0
  task automatic set_dir(input logic [3:0] p, input logic [3:0] n);
    @(posedge clk);
    dn_pos <= p;
    dn_neg <= n;
  endtask
  // Levels held h cycles so the two-flop sync never misses one
  task automatic pulse(input logic [3:0] u, input logic [3:0] w,
                       input int n, input int h);
    repeat (n) begin
      @(posedge clk);
      up_pos <= up_pos | u;
      dn_pos <= dn_pos | w;
      repeat (h) @(posedge clk);
      up_pos <= up_pos & ~u;
      dn_pos <= dn_pos & ~w;
      repeat (h - 1) @(posedge clk);
    end
    repeat (2) @(posedge clk);
  endtask
endmodule // fpca_field_src
`default_nettype wire

// [verif/tb_four_channel_pulse_counter_alarm.sv]
// Self-checking bench for the four-channel pulse counter
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_total++; \
  $display("wrong value at %0t: got %0h exp %0h", $time, g, e); end end
module tb_four_channel_pulse_counter_alarm;
  logic clk, sys_rst, reg_wr, reg_rd, irq, ce;
  logic [7:0] reg_addr, alarm_state;
  logic [31:0] reg_wdata, reg_rdata, d;
  logic [127:0] alarm_do;
  logic [3:0] up_p, up_n, dn_p, dn_n;
  int err_total, checks;
  // Short gate keeps the frequency run brief; scale left at one
  fpca_top #(.GATE_CYCLES(32'h64), .FREQ_SCALE(32'h1)) i_dut (
    .clk(clk), .sys_rst(sys_rst), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .up_count_input_pos(up_p),
    .up_count_input_neg(up_n), .down_input_pos(dn_p),
    .down_input_neg(dn_n), .alarm_state(alarm_state),
    .alarm_do(alarm_do), .irq(irq));
  fpca_field_src i_src (.clk(clk), .up_pos(up_p), .up_neg(up_n),
    .dn_pos(dn_p), .dn_neg(dn_n));
  function automatic logic [7:0] ca(input int ch, input int sub);
    return 8'h10 + 8'(ch * 8 + sub);
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic t_reset;
    rd(8'h00); `CHK(d, 32'h0)
    rd(ca(3, 1)); `CHK(d, 32'hFFFFFFFF)
    rd(ca(1, 6)); `CHK(d, 32'h0)
    rd(8'h09); `CHK(d, 32'h0)
  endtask
  task automatic t_updown;
    wr(8'h00, 32'h0);
    i_src.pulse(4'hF, 4'h0, 3, 3);
    rd(ca(0, 3)); `CHK(d, 32'h3)
    rd(ca(3, 3)); `CHK(d, 32'h3)
    i_src.pulse(4'h0, 4'h1, 1, 3);
    rd(ca(0, 3)); `CHK(d, 32'h2)
    i_src.pulse(4'h1, 4'h1, 1, 3);
    rd(ca(0, 3)); `CHK(d, 32'h2)
    // Enable low: a pulse must leave no trace
    @(posedge clk);
    ce <= 1'b0;
    i_src.pulse(4'h8, 4'h0, 1, 3);
    ce <= 1'b1;
    rd(ca(3, 3)); `CHK(d, 32'h3)
  endtask
  task automatic t_bidir;
    wr(8'h00, 32'h5);
    rd(8'h00); `CHK(d, 32'h5)
    i_src.set_dir(4'h1, 4'h0);
    i_src.pulse(4'h1, 4'h0, 2, 3);
    rd(ca(0, 3)); `CHK(d, 32'h4)
    wr(8'h00, 32'h1);
    i_src.set_dir(4'h0, 4'h0);
    i_src.pulse(4'h1, 4'h0, 1, 3);
    rd(ca(0, 3)); `CHK(d, 32'h3)
  endtask
  task automatic t_wrap;
    wr(8'h00, 32'h0);
    // Start off the bound so a reload differs from saturation
    wr(ca(1, 0), 32'hFFFFFFFE);
    i_src.pulse(4'h2, 4'h0, 2, 3);
    rd(ca(1, 3)); `CHK(d, 32'hFFFFFFFE)
    rd(ca(1, 4)); `CHK(d, 32'h1)
    rd(8'h06); `CHK(d[9], 1'b1)
    wr(ca(1, 0), 32'h2);
    i_src.pulse(4'h0, 4'h2, 3, 3);
    rd(ca(1, 3)); `CHK(d, 32'h2)
    rd(ca(1, 4)); `CHK(d, 32'hFFFFFFFF)
  endtask
  task automatic t_alarm;
    wr(ca(0, 0), 32'h5);
    wr(ca(0, 1), 32'h5);
    wr(8'h01, 32'h1);
    wr(8'h04, 32'h92);
    wr(8'h07, 32'h1FFF);
    wr(8'h08, 32'h1);
    repeat (4) @(posedge clk);
    `CHK(alarm_state, 8'h00)
    i_src.pulse(4'h1, 4'h0, 1, 3);
    repeat (3) @(posedge clk);
    `CHK(alarm_state, 8'h01)
    `CHK(alarm_do, 128'h1 << 18)
    `CHK(irq, 1'b1)
    wr(ca(0, 0), 32'h0);
    repeat (4) @(posedge clk);
    `CHK(alarm_state, 8'h01)
    wr(8'h02, 32'h1);
    repeat (4) @(posedge clk);
    `CHK(alarm_state, 8'h00)
    rd(8'h02); `CHK(d, 32'h0)
    wr(8'h07, 32'h1);
    repeat (3) @(posedge clk);
    `CHK(irq, 1'b0)
    // Low alarm on channel 1, routed to output bit 5
    wr(ca(1, 2), 32'h3);
    wr(8'h01, 32'h20);
    wr(8'h05, 32'h8500);
    repeat (3) @(posedge clk);
    `CHK(alarm_state, 8'h20)
    `CHK(alarm_do, 128'h1 << 5)
  endtask
  task automatic t_freq;
    wr(8'h00, 32'h2);
    rd(8'h00); `CHK(d, 32'h2)
    i_src.pulse(4'h4, 4'hF, 35, 5);
    rd(ca(2, 5)); `CHK(d, 32'hA)
    rd(ca(2, 3)); `CHK(d, 32'h3)
  endtask
  task automatic close_out;
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    sys_rst = 1'b1;
    ce = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset;
    t_updown;
    t_bidir;
    t_wrap;
    t_alarm;
    t_freq;
    close_out;
  end
  // Hang guard
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    close_out;
  end
endmodule // tb_four_channel_pulse_counter_alarm
`default_nettype wire
